//--- design/ldoalt_regs.sv
// The APB slave port was decided locally.
`timescale 1ns/1ps
`include "ldoalt_defs.svh"

module ldoalt_regs
  import ldoalt_pkg::*;
#(
  parameter int ADDR_W = 12
) (
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic [31:0]       pwdata,
  input  wire logic [3:0]        pstrb,
  output logic [31:0]            prdata,
  output logic                   pready,
  output logic                   pslverr,
  output logic                   third_reg_alt_sleep_sel,
  output logic [6:0]             third_reg_alt_voltage_code,
  output logic                   fourth_reg_alt_sleep_sel,
  output logic [6:0]             fourth_reg_alt_voltage_code,
  output logic                   fifth_reg_alt_sleep_sel,
  output logic [5:0]             fifth_reg_alt_voltage_code,
  output logic [15:0]            third_target_mv,
  output logic [15:0]            fourth_target_mv,
  output logic [15:0]            fifth_target_mv
);

  // register map needs ten address bits
  if (ADDR_W < 10) begin : g_addr_chk
    $error("ADDR_W too small for register map");
  end

  ldoalt_state_t st_reg;
  ldoalt_state_t st_next;

  logic [ADDR_W-1:0] a_third;
  logic [ADDR_W-1:0] a_fourth;
  logic [ADDR_W-1:0] a_fifth;
  assign a_third  = ADDR_W'(`LDOALT_THIRD_OFS) << `LDOALT_ADDR_SHIFT;
  assign a_fourth = ADDR_W'(`LDOALT_FOURTH_OFS) << `LDOALT_ADDR_SHIFT;
  assign a_fifth  = ADDR_W'(`LDOALT_FIFTH_OFS) << `LDOALT_ADDR_SHIFT;

  function automatic logic [15:0] mv7(input logic [6:0] c);
    mv7 = 16'(`LDOALT_BASE_MV + 16'(c) * `LDOALT_STEP7_MV);
  endfunction

  function automatic logic [15:0] mv6(input logic [5:0] c);
    logic [5:0] k;
    k = c;
    if (k < `LDOALT_FIFTH_LOW) begin
      k = `LDOALT_FIFTH_LOW;
    end
    if (k > `LDOALT_FIFTH_HIGH) begin
      k = `LDOALT_FIFTH_HIGH;
    end
    mv6 = 16'(`LDOALT_BASE_MV
          + 16'(k - `LDOALT_FIFTH_LOW) * `LDOALT_STEP6_MV);
  endfunction

  logic       access;
  logic       hit;
  logic [7:0] wbyte;

  always_comb begin
    st_next = st_reg;
    access  = psel && penable && !st_reg.pready_reg;
    hit     = (paddr == a_third) || (paddr == a_fourth)
              || (paddr == a_fifth);
    wbyte   = pwdata[7:0];
    st_next.pready_reg  = access;
    st_next.pslverr_reg = access && !hit;
    st_next.prdata_reg  = 32'h0000_0000;
    if (access && pwrite && pstrb[0]) begin
      if (paddr == a_third) begin
        st_next.third_reg = wbyte;
      end
      if (paddr == a_fourth) begin
        st_next.fourth_reg = wbyte;
      end
      if (paddr == a_fifth) begin
        st_next.fifth_reg = wbyte;
        st_next.fifth_reg[`LDOALT_RSVD_BIT] = 1'b0;
      end
    end
    if (access && !pwrite) begin
      if (paddr == a_third) begin
        st_next.prdata_reg = {24'h00_0000, st_reg.third_reg};
      end
      if (paddr == a_fourth) begin
        st_next.prdata_reg = {24'h00_0000, st_reg.fourth_reg};
      end
      if (paddr == a_fifth) begin
        st_next.prdata_reg = {24'h00_0000, st_reg.fifth_reg};
      end
    end
    st_next.third_mv_reg  =
      mv7(st_next.third_reg[`LDOALT_CODE7_MSB:0]);
    st_next.fourth_mv_reg =
      mv7(st_next.fourth_reg[`LDOALT_CODE7_MSB:0]);
    st_next.fifth_mv_reg  =
      mv6(st_next.fifth_reg[`LDOALT_CODE6_MSB:0]);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_reg <= '0;
      st_reg.third_reg  <= `LDOALT_RESET_BYTE;
      st_reg.fourth_reg <= `LDOALT_RESET_BYTE;
      st_reg.fifth_reg  <= `LDOALT_RESET_BYTE;
      st_reg.third_mv_reg  <= `LDOALT_BASE_MV;
      st_reg.fourth_mv_reg <= `LDOALT_BASE_MV;
      st_reg.fifth_mv_reg  <= `LDOALT_BASE_MV;
    end else begin
      st_reg <= st_next;
    end
  end

  assign prdata  = st_reg.prdata_reg;
  assign pready  = st_reg.pready_reg;
  assign pslverr = st_reg.pslverr_reg;
  // sleep select per regulator
  assign third_reg_alt_sleep_sel  = st_reg.third_reg[`LDOALT_SLEEP_BIT];
  assign fourth_reg_alt_sleep_sel = st_reg.fourth_reg[`LDOALT_SLEEP_BIT];
  assign fifth_reg_alt_sleep_sel  = st_reg.fifth_reg[`LDOALT_SLEEP_BIT];
  assign third_reg_alt_voltage_code  = st_reg.third_reg[6:0];
  assign fourth_reg_alt_voltage_code = st_reg.fourth_reg[6:0];
  assign fifth_reg_alt_voltage_code  = st_reg.fifth_reg[5:0];
  assign third_target_mv  = st_reg.third_mv_reg;
  assign fourth_target_mv = st_reg.fourth_mv_reg;
  assign fifth_target_mv  = st_reg.fifth_mv_reg;

endmodule

//--- include/ldoalt_defs.svh
`ifndef LDOALT_DEFS_SVH
`define LDOALT_DEFS_SVH

// register indexes of the three alternate-set registers
`define LDOALT_THIRD_OFS   12'h0BC
`define LDOALT_FOURTH_OFS  12'h0BD
`define LDOALT_FIFTH_OFS   12'h0BE
// index = printed offset, byte address = 4 * index
`define LDOALT_ADDR_SHIFT  2
// field positions
`define LDOALT_SLEEP_BIT   7
`define LDOALT_RSVD_BIT    6
`define LDOALT_CODE7_MSB   6
`define LDOALT_CODE6_MSB   5
// reset values
`define LDOALT_RESET_BYTE  8'h00
// fifth regulator code map: 0.90 V floor, 50 mV steps, 3.60 V ceiling
`define LDOALT_FIFTH_LOW   6'h02
`define LDOALT_FIFTH_HIGH  6'h38
// millivolt figures
`define LDOALT_BASE_MV     16'h0384
`define LDOALT_STEP7_MV    16'h0014
`define LDOALT_STEP6_MV    16'h0032

`endif

//--- include/ldoalt_pkg.sv
package ldoalt_pkg;

  typedef struct packed {
    logic [7:0]  third_reg;
    logic [7:0]  fourth_reg;
    logic [7:0]  fifth_reg;
    logic [31:0] prdata_reg;
    logic        pready_reg;
    logic        pslverr_reg;
    logic [15:0] third_mv_reg;
    logic [15:0] fourth_mv_reg;
    logic [15:0] fifth_mv_reg;
  } ldoalt_state_t;

endpackage

//--- dv/ldoalt_props.sv
`timescale 1ns/1ps
module ldoalt_props
  import ldoalt_pkg::*;
(
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pready,
  input wire logic [6:0]  third_reg_alt_voltage_code,
  input wire logic [15:0] third_target_mv,
  input wire logic [6:0]  fourth_reg_alt_voltage_code,
  input wire logic [15:0] fourth_target_mv,
  input wire logic [5:0]  fifth_reg_alt_voltage_code,
  input wire logic [15:0] fifth_target_mv
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_acc; psel && penable && !pready; endsequence
  sequence s_pulse; pready ##1 !pready; endsequence
  property p_ack; s_acc |=> s_pulse; endproperty
  a_ack: assert property (p_ack) else $error("bad ready");
  property p_third; third_target_mv ==
    16'h0384 + 16'h0014 * third_reg_alt_voltage_code; endproperty
  a_third: assert property (p_third) else $error("third mv");
  property p_top; third_reg_alt_voltage_code == 7'h7F
    |-> third_target_mv == 16'h0D70; endproperty
  a_top: assert property (p_top) else $error("third top");
  property p_fourth; fourth_target_mv ==
    16'h0384 + 16'h0014 * fourth_reg_alt_voltage_code; endproperty
  a_fourth: assert property (p_fourth) else $error("fourth mv");
  property p_low; fifth_reg_alt_voltage_code < 6'h03
    |-> fifth_target_mv == 16'h0384; endproperty
  a_low: assert property (p_low) else $error("fifth low");
  property p_step; fifth_reg_alt_voltage_code inside {[6'h03:6'h37]}
    |-> fifth_target_mv == 16'h0320 + 16'h0032 * fifth_reg_alt_voltage_code;
  endproperty
  a_step: assert property (p_step) else $error("fifth step");
  property p_sat; fifth_reg_alt_voltage_code >= 6'h38
    |-> fifth_target_mv == 16'h0E10; endproperty
  a_sat: assert property (p_sat) else $error("fifth sat");
endmodule
bind ldoalt_regs ldoalt_props i_ldoalt_props (.*);

//--- dv/tb_ldoalt_regs.sv
`timescale 1ns/1ps
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin errors++; \
  $display("[FAIL] %0t got %0h exp %0h", $time, a, b); end end
module tb_ldoalt_regs import ldoalt_pkg::*;;
  logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
  logic        pwrite = 1'b0, pready, pslverr, err_q;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000, prdata, rd;
  logic [3:0]  pstrb = 4'hF;
  logic        third_reg_alt_sleep_sel, fourth_reg_alt_sleep_sel;
  logic        fifth_reg_alt_sleep_sel;
  logic [6:0]  third_reg_alt_voltage_code, fourth_reg_alt_voltage_code;
  logic [5:0]  fifth_reg_alt_voltage_code;
  logic [15:0] third_target_mv, fourth_target_mv, fifth_target_mv;
  int          errors = 0, samples_checked = 0;
  ldoalt_regs i_ldoalt_regs (.*);
  always #12.5 pclk = ~pclk;
  task automatic results();
    $display("errors %0d checked %0d", errors, samples_checked);
    if (errors == 0 && samples_checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) begin
      errors++;
      results();
    end
    rd = prdata;
    err_q = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic t_third();
    apb(1'b1, 12'h2F0, 32'hFFFF_FFFF);
    apb(1'b0, 12'h2F0, 32'h0000_0000);
    `CHK(rd, 32'h0000_00FF)
    `CHK(third_reg_alt_sleep_sel, 1'b1)
    `CHK(third_target_mv, 16'h0D70)
    apb(1'b1, 12'h2F0, 32'h0000_0005);
    `CHK(third_reg_alt_sleep_sel, 1'b0)
    `CHK(third_target_mv, 16'h03E8)
    apb(1'b1, 12'h2F4, 32'h0000_0001);
    `CHK(fourth_target_mv, 16'h0398)
    `CHK(fourth_reg_alt_voltage_code, 7'h01)
    `CHK(fourth_reg_alt_sleep_sel, 1'b0)
    `CHK(third_reg_alt_voltage_code, 7'h05)
    apb(1'b0, 12'h2F4, 32'h0000_0000);
    `CHK(rd, 32'h0000_0001)
    `CHK(err_q, 1'b0)
  endtask
  task automatic t_fifth();
    apb(1'b1, 12'h2F8, 32'h0000_00FF);
    apb(1'b0, 12'h2F8, 32'h0000_0000);
    `CHK(rd, 32'h0000_00BF)
    `CHK(fifth_target_mv, 16'h0E10)
    `CHK(fifth_reg_alt_sleep_sel, 1'b1)
    apb(1'b1, 12'h2F8, 32'h0000_0033);
    `CHK(fifth_target_mv, 16'h0D16)
    `CHK(fifth_reg_alt_voltage_code, 6'h33)
    `CHK(fifth_reg_alt_sleep_sel, 1'b0)
    apb(1'b1, 12'h2F8, 32'h0000_0002);
    `CHK(fifth_target_mv, 16'h0384)
    apb(1'b0, 12'h2FC, 32'h0000_0000);
    `CHK(err_q, 1'b1)
  endtask
  initial begin
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    t_third();
    t_fifth();
    results();
  end
endmodule
